// ==== rtl/setup_frame_filter.sv ====
`default_nettype none
module setup_frame_filter
	import setup_filter_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic [BUS_AW-1:0]      avs_address_i,
	input  wire logic                   avs_read_i,
	input  wire logic                   avs_write_i,
	input  wire logic [31:0]            avs_writedata_i,
	output logic [31:0]                 avs_readdata_o,
	output logic                        avs_waitrequest_o,
	input  wire logic                   desc_valid_i,
	output logic                        desc_ready_o,
	input  wire logic [31:0]            desc_control_i,
	input  wire logic [31:0]            desc_first_ptr_i,
	input  wire logic [31:0]            desc_second_ptr_i,
	output logic [31:0]                 buf_one_addr_o,
	output logic [31:0]                 buf_two_addr_o,
	output logic                        xmit_valid_o,
	input  wire logic                   setup_data_valid_i,
	output logic                        setup_data_ready_o,
	input  wire logic [31:0]            setup_data_i,
	output logic                        close_valid_o,
	output logic [31:0]                 close_word_o,
	input  wire logic                   tx_running_i,
	input  wire logic                   tx_drained_i,
	input  wire logic                   rx_busy_i,
	output logic                        rx_disconnect_o,
	input  wire logic                   tx_done_i,
	input  wire setup_filter_pkg::tx_cause_e tx_cause_i,
	input  wire logic [31:0]            tx_raw_status_i,
	output logic                        tx_status_valid_o,
	output logic [31:0]                 tx_status_o,
	input  wire logic                   dest_valid_i,
	output logic                        dest_ready_o,
	input  wire logic [47:0]            dest_addr_i,
	output logic                        verdict_valid_o,
	output logic                        verdict_accept_o
);
	import setup_filter_pkg::*;

	// ==========================================================
	// State and storage
	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_LOAD, S_CLOSE} setup_state_e;
	typedef enum logic [1:0] {F_IDLE, F_READ, F_COMPARE, F_DONE} filt_state_e;

	setup_state_e      s_state_reg;
	filt_state_e       f_state_reg;
	logic [31:0]       mode_reg;
	logic              loaded_reg;
	logic [31:0]       ctrl_reg;
	logic [31:0]       buf_one_reg;
	logic [31:0]       buf_two_reg;
	logic              xmit_reg;
	logic              close_reg;
	logic [TBL_AW-1:0] load_cnt_reg;
	logic              ack_reg;
	logic [31:0]       rdata_reg;
	logic              txs_valid_reg;
	logic [31:0]       txs_reg;
	logic [47:0]       dest_reg;
	logic [HASH_W-1:0] hash_idx_reg;
	logic              hash_look_reg;
	logic [TBL_AW-1:0] scan_addr_reg;
	logic [TBL_AW-1:0] scan_last_reg;
	logic [1:0]        part_reg;
	logic              entry_ok_reg;
	logic              any_hit_reg;
	logic              accept_reg;

	table_mem_if tbl ();

	setup_table_mem u_table (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tbl   (tbl)
	);

	// ==========================================================
	// Ethernet CRC over the six destination bytes, first byte first, LSB first.
	function automatic logic [HASH_W-1:0] hash_index(input logic [47:0] addr);
		logic [31:0] crc;
		crc = CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			if (crc[0] ^ addr[i]) begin
				crc = (crc >> 1) ^ CRC_POLY;
			end else begin
				crc = crc >> 1;
			end
		end
		return crc[HASH_W-1:0];
	endfunction

	// ==========================================================
	// Decoding
	wire        bus_req      = (avs_read_i | avs_write_i) & ~ack_reg;
	wire        sel_mode     = avs_address_i == REG_MODE_ADDR;
	wire        sel_status   = avs_address_i == REG_STATUS_ADDR;
	wire        sw_mode_wr   = ack_reg & avs_write_i & sel_mode;
	wire [1:0]  ft_bits      = {ctrl_reg[CTRL_FT_HIGH_BIT], ctrl_reg[CTRL_FT_LOW_BIT]};
	wire        is_setup     = desc_control_i[CTRL_SETUP_BIT];
	wire        take_desc    = desc_valid_i & desc_ready_o;
	wire        len_one_zero = ctrl_reg[LEN_ONE_LSB +: LEN_W] == LEN_ZERO;
	wire        len_two_zero = ctrl_reg[LEN_TWO_LSB +: LEN_W] == LEN_ZERO;
	wire        quiet        = tx_running_i & tx_drained_i & ~rx_busy_i & (f_state_reg == F_IDLE);
	wire        load_beat    = setup_data_valid_i & setup_data_ready_o;
	wire        load_done    = load_beat & (load_cnt_reg == TBL_LAST);
	wire        hw_mode_wr   = (s_state_reg == S_CLOSE) & ctrl_reg[CTRL_SETUP_BIT];
	wire        take_dest    = dest_valid_i & dest_ready_o;
	wire        mode_hash    = mode_reg[MODE_HASH_BIT];
	wire        mode_honly   = mode_reg[MODE_HONLY_BIT];
	wire        mode_inv     = mode_reg[MODE_INV_BIT];
	wire        mode_prom    = mode_reg[MODE_PROM_BIT];
	wire        dest_multi   = dest_addr_i[0];
	wire        use_hash     = mode_honly | (mode_hash & dest_multi);
	wire [HASH_W-1:0] new_idx = hash_index(dest_addr_i);
	wire [TBL_DW-1:0] dest_chunk = (part_reg == PART_FIRST) ? dest_reg[15:0] :
	                               (part_reg == PART_MID)   ? dest_reg[31:16] :
	                                                          dest_reg[47:32];
	wire        word_ok      = tbl.rd_data == dest_chunk;
	wire        hash_bit     = tbl.rd_data[hash_idx_reg[3:0]];
	wire        entry_hit    = (part_reg == PART_LAST) & entry_ok_reg & word_ok;
	wire        hit_final    = hash_look_reg ? hash_bit : (any_hit_reg | entry_hit);
	wire        scan_end     = scan_addr_reg == scan_last_reg;
	wire        perfect_now  = ~mode_hash & ~mode_honly;
	wire [31:0] status_word  = {29'h0000_0000, s_state_reg != S_IDLE, rx_disconnect_o,
	                            loaded_reg};
	wire [31:0] valid_mask   = (tx_cause_i == CAUSE_UNDERFLOW) ? MASK_UNDERFLOW :
	                           (tx_cause_i == CAUSE_LOOPBACK)  ? MASK_UNDERFLOW :
	                           (tx_cause_i == CAUSE_EXCESS)    ? MASK_EXCESS :
	                           (tx_cause_i == CAUSE_WATCHDOG)  ? MASK_WATCHDOG :
	                                                             MASK_ALL;

	// ==========================================================
	// Outputs and table port
	assign avs_waitrequest_o  = (avs_read_i | avs_write_i) & ~ack_reg;
	assign avs_readdata_o     = rdata_reg;
	assign desc_ready_o       = s_state_reg == S_IDLE;
	assign buf_one_addr_o     = buf_one_reg;
	assign buf_two_addr_o     = buf_two_reg;
	assign xmit_valid_o       = xmit_reg;
	assign setup_data_ready_o = s_state_reg == S_LOAD;
	assign close_valid_o      = close_reg;
	assign close_word_o       = CLOSE_WORD;
	// Disconnecting the receiver only gates the medium; receive state is untouched.
	assign rx_disconnect_o    = (s_state_reg == S_LOAD) | (s_state_reg == S_CLOSE);
	assign tx_status_valid_o  = txs_valid_reg;
	assign tx_status_o        = txs_reg;
	assign dest_ready_o       = (f_state_reg == F_IDLE) & ~rx_disconnect_o;
	assign verdict_valid_o    = f_state_reg == F_DONE;
	assign verdict_accept_o   = accept_reg;
	assign tbl.wr_en          = load_beat;
	assign tbl.wr_addr        = load_cnt_reg;
	assign tbl.wr_data        = setup_data_i[TBL_DW-1:0];
	assign tbl.rd_en          = f_state_reg == F_READ;
	assign tbl.rd_addr        = scan_addr_reg;

	// ==========================================================
	// Register bus: every access is answered one cycle after it appears.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= '0;
		end else begin
			ack_reg   <= bus_req;
			rdata_reg <= ~(bus_req & avs_read_i) ? rdata_reg :
			             sel_mode ? mode_reg : sel_status ? status_word : '0;
		end
	end

	// The setup frame wins over a software write in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= MODE_RESET;
		end else if (hw_mode_wr) begin
			mode_reg[MODE_HASH_BIT]  <= ft_bits == FT_HASH;
			mode_reg[MODE_HONLY_BIT] <= ft_bits == FT_HASH_ONLY;
			mode_reg[MODE_INV_BIT]   <= ft_bits == FT_INVERSE;
		end else if (sw_mode_wr) begin
			mode_reg <= avs_writedata_i;
		end
	end

	// ==========================================================
	// Descriptor and setup frame sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_state_reg  <= S_IDLE;
			ctrl_reg     <= '0;
			buf_one_reg  <= '0;
			buf_two_reg  <= '0;
			xmit_reg     <= 1'b0;
			close_reg    <= 1'b0;
			load_cnt_reg <= TBL_FIRST;
			loaded_reg   <= 1'b0;
		end else begin
			xmit_reg  <= 1'b0;
			close_reg <= 1'b0;
			case (s_state_reg)
				S_IDLE: begin
					if (take_desc) begin
						ctrl_reg    <= desc_control_i;
						buf_one_reg <= desc_first_ptr_i;
						buf_two_reg <= desc_second_ptr_i;
						if (is_setup) begin
							s_state_reg <= S_WAIT;
						end else begin
							xmit_reg <= 1'b1;
						end
					end
				end
				S_WAIT: begin
					if (quiet) begin
						load_cnt_reg <= TBL_FIRST;
						// A zero-length setup descriptor only switches the mode.
						s_state_reg  <= (len_one_zero & len_two_zero) ? S_CLOSE : S_LOAD;
					end
				end
				S_LOAD: begin
					if (load_beat) begin
						load_cnt_reg <= load_cnt_reg + 6'h01;
					end
					if (load_done) begin
						loaded_reg  <= 1'b1;
						s_state_reg <= S_CLOSE;
					end
				end
				S_CLOSE: begin
					close_reg   <= 1'b1;
					s_state_reg <= S_IDLE;
				end
				default: begin
					s_state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Transmit completion status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txs_valid_reg <= 1'b0;
			txs_reg       <= '0;
		end else begin
			txs_valid_reg <= tx_done_i;
			if (tx_done_i) begin
				txs_reg <= tx_raw_status_i & valid_mask;
			end
		end
	end

	// ==========================================================
	// Destination filter: one table word per two cycles, so a perfect
	// scan costs about a hundred cycles per frame; cheap in area, and
	// well inside a minimum frame time.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			f_state_reg   <= F_IDLE;
			dest_reg      <= '0;
			hash_idx_reg  <= '0;
			hash_look_reg <= 1'b0;
			scan_addr_reg <= TBL_FIRST;
			scan_last_reg <= TBL_LAST;
			part_reg      <= PART_FIRST;
			entry_ok_reg  <= 1'b1;
			any_hit_reg   <= 1'b0;
			accept_reg    <= 1'b0;
		end else begin
			case (f_state_reg)
				F_IDLE: begin
					if (take_dest) begin
						dest_reg      <= dest_addr_i;
						hash_idx_reg  <= new_idx;
						hash_look_reg <= use_hash;
						part_reg      <= PART_FIRST;
						entry_ok_reg  <= 1'b1;
						any_hit_reg   <= 1'b0;
						if (mode_prom) begin
							accept_reg  <= 1'b1;
							f_state_reg <= F_DONE;
						end else begin
							f_state_reg <= F_READ;
						end
						if (use_hash) begin
							scan_addr_reg <= {1'b0, new_idx[HASH_W-1:4]};
						end else if (mode_hash) begin
							scan_addr_reg <= HASH_PHYS_BASE;
							scan_last_reg <= HASH_PHYS_LAST;
						end else begin
							scan_addr_reg <= TBL_FIRST;
							scan_last_reg <= TBL_LAST;
						end
					end
				end
				F_READ: begin
					f_state_reg <= F_COMPARE;
				end
				F_COMPARE: begin
					if (hash_look_reg | scan_end) begin
						accept_reg  <= (perfect_now & mode_inv) ? ~hit_final : hit_final;
						f_state_reg <= F_DONE;
					end else begin
						scan_addr_reg <= scan_addr_reg + 6'h01;
						f_state_reg   <= F_READ;
					end
					if (part_reg == PART_LAST) begin
						part_reg     <= PART_FIRST;
						entry_ok_reg <= 1'b1;
						any_hit_reg  <= any_hit_reg | entry_hit;
					end else begin
						part_reg     <= part_reg + 2'h1;
						entry_ok_reg <= entry_ok_reg & word_ok;
					end
				end
				F_DONE: begin
					f_state_reg <= F_IDLE;
				end
				default: begin
					f_state_reg <= F_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== common/setup_filter_pkg.sv ====
//
// Contract
// - Filter type 00 on a setup descriptor loads 16 addresses, selects perfect filtering.
// - Type 01 loads 512-bit hash plus one exact physical address.
// - Type 10 loads 16 addresses; accept non-matching, reject matching destinations.
// - Type 11 loads only the hash; all destinations filtered by hash.
// - Filter-type bits count only when the filter_load_flag bit 27 is set.
// - Third descriptor word is the full first buffer address.
// - Fourth descriptor word is the full second buffer address.
// - Transmit status bits invalid for the termination cause are reported as zero.
// - A setup frame is never transmitted nor looped back.
// - Receive logic is disconnected from the medium while a setup frame loads.
// - Setup descriptor closes with ownership cleared and all other bits set.
// - Setup waits for running transmit, drained queue and finished reception.
// - Setup processing leaves the receive process state unchanged.
// - Perfect mode compares 16 full addresses; inverse bit flips the verdict.
// - Bit 0 of the first destination byte marks a multicast address.
// - Multicast hash uses the Ethernet CRC of 6 bytes, 9 bits index.
// - Hash bits count from bit 0 of each longword onward through longwords.
`default_nettype none
package setup_filter_pkg;

	// ==========================================================
	// Register bus
	localparam int          BUS_AW          = 4;
	localparam logic [3:0]  REG_MODE_ADDR   = 4'h0;
	localparam logic [3:0]  REG_STATUS_ADDR = 4'h4;
	localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
	localparam int          MODE_HASH_BIT   = 0;
	localparam int          MODE_HONLY_BIT  = 2;
	localparam int          MODE_INV_BIT    = 4;
	localparam int          MODE_PROM_BIT   = 6;
	localparam int          STAT_LOADED_BIT = 0;
	localparam int          STAT_DISC_BIT   = 1;
	localparam int          STAT_BUSY_BIT   = 2;

	// ==========================================================
	// Descriptor control word fields
	localparam int CTRL_FT_HIGH_BIT = 28;
	localparam int CTRL_FT_LOW_BIT  = 22;
	localparam int CTRL_SETUP_BIT   = 27;
	localparam int LEN_W            = 11;
	localparam int LEN_ONE_LSB      = 0;
	localparam int LEN_TWO_LSB      = 11;
	localparam logic [LEN_W-1:0] LEN_ZERO = 11'h000;
	localparam logic [1:0] FT_PERFECT   = 2'h0;
	localparam logic [1:0] FT_HASH      = 2'h1;
	localparam logic [1:0] FT_INVERSE   = 2'h2;
	localparam logic [1:0] FT_HASH_ONLY = 2'h3;
	localparam logic [31:0] CLOSE_WORD  = 32'h7FFF_FFFF;

	// ==========================================================
	// Filter table
	localparam int TBL_AW    = 6;
	localparam int TBL_DW    = 16;
	localparam int TBL_WORDS = 48;
	localparam logic [TBL_AW-1:0] TBL_FIRST      = 6'h00;
	localparam logic [TBL_AW-1:0] TBL_LAST       = 6'h2F;
	localparam logic [TBL_AW-1:0] HASH_PHYS_BASE = 6'h27;
	localparam logic [TBL_AW-1:0] HASH_PHYS_LAST = 6'h29;
	localparam logic [1:0] PART_FIRST = 2'h0;
	localparam logic [1:0] PART_MID   = 2'h1;
	localparam logic [1:0] PART_LAST  = 2'h2;
	localparam int HASH_W = 9;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

	// ==========================================================
	// Transmit status validity masks
	localparam logic [31:0] MASK_ALL       = 32'hFFFF_FFFF;
	localparam logic [31:0] MASK_UNDERFLOW = 32'hFFFF_F37F;
	localparam logic [31:0] MASK_EXCESS    = 32'hFFFF_FF87;
	localparam logic [31:0] MASK_WATCHDOG  = 32'hFFFF_C47B;

	typedef enum logic [2:0] {
		CAUSE_NORMAL,
		CAUSE_UNDERFLOW,
		CAUSE_EXCESS,
		CAUSE_WATCHDOG,
		CAUSE_LOOPBACK
	} tx_cause_e;

endpackage
`default_nettype wire

// ==== common/table_mem_if.sv ====
`default_nettype none
interface table_mem_if;
	import setup_filter_pkg::*;
	logic              wr_en;
	logic [TBL_AW-1:0] wr_addr;
	logic [TBL_DW-1:0] wr_data;
	logic              rd_en;
	logic [TBL_AW-1:0] rd_addr;
	logic [TBL_DW-1:0] rd_data;
	modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== rtl/setup_table_mem.sv ====
`default_nettype none
module setup_table_mem
	import setup_filter_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	table_mem_if.mem   tbl
);
	logic [TBL_DW-1:0] store [TBL_WORDS];
	logic [TBL_DW-1:0] rd_data_reg;

	assign tbl.rd_data = rd_data_reg;

	always_ff @(posedge clk_i) begin
		if (tbl.wr_en) begin
			store[tbl.wr_addr] <= tbl.wr_data;
		end
	end

	// Read data come one cycle after the read strobe.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_reg <= '0;
		end else if (tbl.rd_en) begin
			rd_data_reg <= store[tbl.rd_addr];
		end
	end
endmodule
`default_nettype wire

// ==== tb/setup_frame_filter_monitor.sv ====
`default_nettype none
module setup_frame_filter_monitor
	import setup_filter_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        desc_valid_i,
	input wire logic        desc_ready_o,
	input wire logic [31:0] desc_control_i,
	input wire logic [31:0] desc_first_ptr_i,
	input wire logic [31:0] desc_second_ptr_i,
	input wire logic [31:0] buf_one_addr_o,
	input wire logic [31:0] buf_two_addr_o,
	input wire logic        xmit_valid_o,
	input wire logic        setup_data_ready_o,
	input wire logic        close_valid_o,
	input wire logic [31:0] close_word_o,
	input wire logic        tx_running_i,
	input wire logic        tx_drained_i,
	input wire logic        rx_busy_i,
	input wire logic        rx_disconnect_o,
	input wire logic        dest_ready_o,
	input wire logic        tx_done_i,
	input wire logic        tx_status_valid_o
);
	// ==========================================================
	// Descriptor, setup load and status checks
	default clocking mon_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence take_s;
		desc_valid_i && desc_ready_o;
	endsequence
	sequence plain_take_s;
		take_s ##0 !desc_control_i[CTRL_SETUP_BIT];
	endsequence
	sequence setup_take_s;
		take_s ##0 desc_control_i[CTRL_SETUP_BIT];
	endsequence
	AST_PLAIN_XMIT: assert property (plain_take_s |=> xmit_valid_o)
		else $error("plain descriptor gave no transmit pulse");
	// A setup frame must stay off the wire, so no transmit pulse may follow it in the next two cycles.
	AST_SETUP_SILENT: assert property (setup_take_s |=> !xmit_valid_o [*2])
		else $error("setup descriptor was transmitted");
	AST_BUF_ONE: assert property (take_s |=> buf_one_addr_o == $past(desc_first_ptr_i))
		else $error("first buffer address differs");
	AST_BUF_TWO: assert property (take_s |=> buf_two_addr_o == $past(desc_second_ptr_i))
		else $error("second buffer address differs");
	AST_SETUP_HOLD: assert property (setup_take_s |=> !desc_ready_o [*2])
		else $error("queue moved on during setup");
	AST_CLOSE_WORD: assert property (close_valid_o |-> close_word_o == 32'h7FFF_FFFF)
		else $error("close word wrong");
	AST_LOAD_DISC: assert property (setup_data_ready_o |-> rx_disconnect_o && !dest_ready_o)
		else $error("receiver attached during load");
	AST_LOAD_GATE: assert property ($rose(setup_data_ready_o) |->
		$past(tx_running_i && tx_drained_i && !rx_busy_i))
		else $error("load began too early");
	AST_DISC_END: assert property ($fell(rx_disconnect_o) |-> close_valid_o)
		else $error("receiver reattached without close");
	AST_STATUS_PULSE: assert property (tx_done_i |=> tx_status_valid_o)
		else $error("status report missing");
endmodule
bind setup_frame_filter setup_frame_filter_monitor mon_u (.clk_i, .rst_i, .desc_valid_i,
	.desc_ready_o, .desc_control_i, .desc_first_ptr_i, .desc_second_ptr_i, .buf_one_addr_o,
	.buf_two_addr_o, .xmit_valid_o, .setup_data_ready_o, .close_valid_o, .close_word_o,
	.tx_running_i, .tx_drained_i, .rx_busy_i, .rx_disconnect_o, .dest_ready_o, .tx_done_i,
	.tx_status_valid_o);
`default_nettype wire

// ==== tb/setup_host_model.sv ====
`default_nettype none
module setup_host_model (
	input wire logic   clk_i,
	input wire logic   rst_i,
	input wire logic   start_i,
	input wire logic   slow_i,
	input wire logic   ready_i,
	output logic       valid_o,
	output logic [31:0] data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Host buffer: 48 longwords, one aligned piece, whole 16-entry table
	logic [31:0] mem [48];
	logic        run;
	int          beat;
	always @(posedge clk_i) begin
		if (rst_i) begin
			run <= 1'b0;
			valid_o <= 1'b0;
			beat <= 0;
			data_o <= 32'h0000_0000;
		end else if (start_i) begin
			run <= 1'b1;
			beat <= 0;
		end else if (valid_o && ready_i) begin
			beat <= beat + 1;
			run <= beat < 47;
			valid_o <= !slow_i && beat < 47;
			// Idle data is inverted so a stale word is never read as fresh.
			data_o <= (!slow_i && beat < 47) ? mem[beat + 1] : ~data_o;
		end else if (run && !valid_o) begin
			valid_o <= 1'b1;
			data_o <= mem[beat];
		end
	end
endmodule
`default_nettype wire

// ==== tb/setup_frame_filter_tb.sv ====
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
`define WAITFOR(s) while ((s) !== 1'b1) @(negedge clk_i);
module setup_frame_filter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import setup_filter_pkg::*;
	localparam logic [47:0] MC_A = 48'h0000_5E00_0001;
	localparam logic [47:0] MC_B = 48'h1234_0000_0033;
	localparam logic [47:0] PH_P = 48'h0A0B_0C0D_0E02;
	localparam logic [47:0] PH_Q = 48'h6655_4433_2210;
	logic              clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [BUS_AW-1:0] avs_address_i;
	logic [31:0]       avs_writedata_i, avs_readdata_o, desc_control_i, desc_first_ptr_i;
	logic [31:0]       desc_second_ptr_i, buf_one_addr_o, buf_two_addr_o, setup_data_i;
	logic [31:0]       close_word_o, tx_raw_status_i, tx_status_o;
	logic              desc_valid_i, desc_ready_o, xmit_valid_o, setup_data_valid_i;
	logic              setup_data_ready_o, close_valid_o, tx_running_i, tx_drained_i;
	logic              rx_busy_i, rx_disconnect_o, tx_done_i, tx_status_valid_o;
	logic              dest_valid_i, dest_ready_o, verdict_valid_o, verdict_accept_o;
	logic              start_load, slow_load;
	logic [47:0]       dest_addr_i;
	logic [511:0]      hbits;
	tx_cause_e         tx_cause_i;
	int                n_errors, samples_checked;
	setup_frame_filter dut_u (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .desc_valid_i, .desc_ready_o,
		.desc_control_i, .desc_first_ptr_i, .desc_second_ptr_i, .buf_one_addr_o,
		.buf_two_addr_o, .xmit_valid_o, .setup_data_valid_i, .setup_data_ready_o,
		.setup_data_i, .close_valid_o, .close_word_o, .tx_running_i, .tx_drained_i,
		.rx_busy_i, .rx_disconnect_o, .tx_done_i, .tx_cause_i, .tx_raw_status_i,
		.tx_status_valid_o, .tx_status_o, .dest_valid_i, .dest_ready_o, .dest_addr_i,
		.verdict_valid_o, .verdict_accept_o);
	setup_host_model host_u (.clk_i, .rst_i, .start_i(start_load), .slow_i(slow_load),
		.ready_i(setup_data_ready_o), .valid_o(setup_data_valid_i), .data_o(setup_data_i));
	// ==========================================================
	// Helpers
	function automatic logic [8:0] hidx(input logic [47:0] a);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 48; i++)
			c = (c[0] ^ a[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c[8:0];
	endfunction
	function automatic logic [47:0] addr_of(input int n);
		return {40'h5E_31_C4_7A_22, 8'(2 * n + (n == 7))};
	endfunction
	task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= wd;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0)
			@(posedge clk_i);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic send_desc(input logic [31:0] c, p1, p2, input logic xm);
		desc_control_i <= c;
		desc_first_ptr_i <= p1;
		desc_second_ptr_i <= p2;
		desc_valid_i <= 1'b1;
		@(negedge clk_i);
		`WAITFOR(desc_ready_o)
		@(posedge clk_i);
		desc_valid_i <= 1'b0;
		@(negedge clk_i);
		`CHK(xmit_valid_o, xm)
		if (xm) begin
			`CHK(buf_one_addr_o, p1)
			`CHK(buf_two_addr_o, p2)
		end
		@(posedge clk_i);
	endtask
	task automatic chk_dest(input logic [47:0] a, input logic exp);
		dest_addr_i <= a;
		dest_valid_i <= 1'b1;
		@(negedge clk_i);
		`WAITFOR(dest_ready_o)
		@(posedge clk_i);
		dest_valid_i <= 1'b0;
		dest_addr_i <= ~a;
		@(negedge clk_i);
		`WAITFOR(verdict_valid_o)
		@(negedge clk_i);
		`CHK(verdict_accept_o, exp)
		@(posedge clk_i);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		bus(1'b0, REG_MODE_ADDR, 32'h0, d);
		`CHK(d, 32'h0000_0000)
		bus(1'b1, 4'h8, 32'hFFFF_FFFF, d);
		bus(1'b0, 4'h8, 32'h0, d);
		`CHK(d, 32'h0000_0000)
		bus(1'b1, REG_MODE_ADDR, 32'h0000_0050, d);
		bus(1'b0, REG_MODE_ADDR, 32'h0, d);
		`CHK(d, 32'h0000_0050)
		chk_dest(PH_Q, 1'b1);
		bus(1'b1, REG_MODE_ADDR, 32'h0, d);
		$display("test registers done");
	endtask
	task automatic t_desc();
		logic [31:0] d;
		send_desc(32'h1040_0040, 32'h1234_5678, 32'h9ABC_DEF0, 1'b1);
		send_desc(32'h0000_0010, 32'hFFFF_FFFC, 32'h0000_0004, 1'b1);
		bus(1'b0, REG_MODE_ADDR, 32'h0, d);
		`CHK(d, 32'h0000_0000)
		$display("test descriptors done");
	endtask
	task automatic t_status();
		logic [31:0] m [5] = '{32'hFFFF_FFFF, 32'hFFFF_F37F, 32'hFFFF_FF87, 32'hFFFF_C47B,
			32'hFFFF_F37F};
		for (int i = 0; i < 5; i++) begin
			tx_cause_i <= tx_cause_e'(i);
			tx_raw_status_i <= 32'hFFFF_FFFF;
			tx_done_i <= 1'b1;
			@(posedge clk_i);
			tx_done_i <= 1'b0;
			@(negedge clk_i);
			`CHK({tx_status_valid_o, tx_status_o}, {1'b1, m[i]})
			@(posedge clk_i);
		end
		$display("test status done");
	endtask
	// The gates open in turn (running, receive idle, drained), and the load must not start before all three are open.
	task automatic t_setup(input logic [1:0] ft, input logic zl);
		logic [31:0] d;
		logic        seen;
		seen = 1'b0;
		{tx_running_i, rx_busy_i, tx_drained_i} <= 3'b010;
		start_load <= !zl;
		slow_load <= ft[0];
		send_desc({3'b000, ft[1], 1'b1, 4'h0, ft[0], 11'h000, zl ? 11'h000 : 11'h0C0},
			32'h0000_1000, 32'h0, 1'b0);
		start_load <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			repeat (6) @(negedge clk_i);
			`CHK(setup_data_ready_o | close_valid_o, 1'b0)
			@(posedge clk_i);
			{tx_running_i, rx_busy_i, tx_drained_i} <= (i == 0) ? 3'b110 :
				(i == 1) ? 3'b100 : 3'b101;
		end
		for (int n = 0; n < 400 && close_valid_o !== 1'b1; n++) begin
			@(negedge clk_i);
			seen |= setup_data_ready_o === 1'b1;
		end
		`CHK({close_valid_o, close_word_o}, {1'b1, 32'h7FFF_FFFF})
		`CHK(seen, !zl)
		@(posedge clk_i);
		bus(1'b0, REG_MODE_ADDR, 32'h0, d);
		`CHK({d[MODE_HONLY_BIT], d[MODE_HASH_BIT], d[MODE_INV_BIT]},
			{&ft, ft == 2'h1, ft == 2'h2})
		$display("test setup load done");
	endtask
	task automatic t_perfect(input logic inv);
		logic [47:0] a;
		for (int n = 0; n < 16; n++) begin
			a = addr_of(n);
			for (int k = 0; k < 3; k++)
				host_u.mem[3 * n + k] = {16'hA5A5, a[16 * k +: 16]};
		end
		t_setup(inv ? FT_INVERSE : FT_PERFECT, 1'b0);
		for (int n = 0; n < 16; n += 7)
			chk_dest(addr_of(n), !inv);
		chk_dest(addr_of(15), !inv);
		chk_dest(addr_of(4) ^ 48'h0000_0100_0000, inv);
		$display("test perfect filter done");
	endtask
	task automatic t_hash(input logic only);
		hbits = '0;
		hbits[hidx(MC_A)] = 1'b1;
		hbits[hidx(PH_Q)] = 1'b1;
		for (int w = 0; w < 48; w++)
			host_u.mem[w] = (w < 32) ? {16'hC3C3, hbits[16 * w +: 16]} : 32'h0;
		for (int k = 0; k < 3; k++)
			host_u.mem[39 + k] = {16'h3C3C, PH_P[16 * k +: 16]};
		t_setup(only ? FT_HASH_ONLY : FT_HASH, 1'b0);
		t_setup(only ? FT_HASH_ONLY : FT_HASH, 1'b1);
		chk_dest(MC_A, 1'b1);
		chk_dest(MC_B, hbits[hidx(MC_B)]);
		chk_dest(PH_P, only ? hbits[hidx(PH_P)] : 1'b1);
		chk_dest(PH_Q, only);
		$display("test hash filter done");
	endtask
	task automatic stop_test();
		$display("checked %0d values, %0d wrong", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Clock, sequence and watchdog
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, avs_read_i, avs_write_i, desc_valid_i, dest_valid_i, tx_done_i} = 6'h20;
		{avs_address_i, avs_writedata_i, desc_control_i, desc_first_ptr_i} = '0;
		{desc_second_ptr_i, tx_raw_status_i, dest_addr_i} = '0;
		{tx_running_i, tx_drained_i, rx_busy_i, start_load, slow_load} = 5'h00;
		tx_cause_i = CAUSE_NORMAL;
		n_errors = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_desc();
		t_status();
		t_perfect(1'b0);
		t_perfect(1'b1);
		t_hash(1'b0);
		t_hash(1'b1);
		stop_test();
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		n_errors++;
		stop_test();
	end
endmodule
`undef CHK
`undef WAITFOR
`default_nettype wire
